// ---- design/ext_packed_media_ops_tail.sv ----
`timescale 1ns/1ps
`include "media_ops_cfg.svh"
module ext_packed_media_ops_tail (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // issue from decode
  input wire logic issue_i,
  input wire logic [15:0] opcode_i,
  input wire logic [1:0] modrm_mod_i,
  input wire logic [2:0] dest_media_reg_i,
  input wire logic [2:0] src_media_reg_i,
  input wire logic [63:0] mem_operand_i,
  // register file read
  output logic [2:0] rd_sel_a_o,
  output logic [2:0] rd_sel_b_o,
  output logic [2:0] rd_sel_c_o,
  input wire logic [63:0] rd_data_a_i,
  input wire logic [63:0] rd_data_b_i,
  input wire logic [63:0] rd_data_c_i,
  // result
  output logic busy_o,
  output logic result_valid_o,
  output logic [2:0] result_reg_o,
  output logic [63:0] result_o,
  output logic illegal_o
);
  // selector outputs are registered copies of the issue-port selectors, one cycle late;
  // operand data is used in the issue cycle, so the regfile must decode the live selectors
  media_ops_pkg::state_e state_q, state_d;
  media_ops_pkg::op_e op_sel;
  logic [2:0] implied_sel;
  logic use_mem;
  logic [63:0] src_val, dst_val, imp_val;
  logic [2:0] sel_a_q, sel_a_d, sel_b_q, sel_b_d, sel_c_q, sel_c_d;
  logic [63:0] res_q, res_d, mul_q, mul_d;
  logic [2:0] wreg_q, wreg_d;
  logic valid_q, valid_d, busy_q, busy_d, ill_q, ill_d;
  logic [63:0] mul_res, sub_res, cmov_res;

  // implied register pairs each register with its neighbour
  assign implied_sel = dest_media_reg_i ^ `IMPLIED_XOR; // see [RULE11]
  assign use_mem = (modrm_mod_i != `MOD_REG_FORM); // see [RULE8]

  always_comb
  begin
    case (opcode_i)
      `OPC_MUL_HIGH_ROUND_IMPLIED: op_sel = media_ops_pkg::OP_MUL_HIGH_ROUND_IMPLIED;
      `OPC_MUL_HIGH_ROUND: op_sel = media_ops_pkg::OP_MUL_HIGH_ROUND;
      `OPC_COND_MOVE_BYTE_NONNEG: op_sel = media_ops_pkg::OP_COND_MOVE_BYTE_NONNEG;
      `OPC_COND_MOVE_BYTE_NEG: op_sel = media_ops_pkg::OP_COND_MOVE_BYTE_NEG;
      `OPC_COND_MOVE_BYTE_NONZERO: op_sel = media_ops_pkg::OP_COND_MOVE_BYTE_NONZERO;
      `OPC_COND_MOVE_BYTE_ZERO: op_sel = media_ops_pkg::OP_COND_MOVE_BYTE_ZERO;
      `OPC_SUB_SAT_WORD_IMPLIED: op_sel = media_ops_pkg::OP_SUB_SAT_WORD_IMPLIED;
      default: op_sel = media_ops_pkg::OP_NONE;
    endcase
  end

  // register operands come from the regfile the cycle of issue (read data is combinational on selectors)
  assign src_val = use_mem ? mem_operand_i : rd_data_b_i; // see [RULE8]
  assign dst_val = rd_data_a_i;
  assign imp_val = rd_data_c_i; // see [RULE11]

  function automatic logic [15:0] mul_lane(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    logic [31:0] r;
    p = $signed(a) * $signed(b);
    r = 32'(p) + `ROUND_HALF; // see [RULE2]
    mul_lane = r[`PROD_HI:`PROD_LO]; // see [RULE1]
  endfunction

  function automatic logic [15:0] sub_sat(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] d;
    d = $signed({a[15], a}) - $signed({b[15], b});
    if (d > $signed({1'b0, `WORD_MAX}))
      sub_sat = `WORD_MAX; // see [RULE10]
    else if (d < $signed({1'b1, `WORD_MIN}))
      sub_sat = `WORD_MIN; // see [RULE10]
    else
      sub_sat = d[15:0];
  endfunction

  // lane datapath runs every cycle; the state machine below only picks which result to keep
  for (genvar gw = 0; gw < `WORD_LANES; gw++)
  begin : g_word
    logic [`WORD_W-1:0] s_w, d_w;
    assign s_w = src_val[gw*`WORD_W +: `WORD_W];
    assign d_w = dst_val[gw*`WORD_W +: `WORD_W];
    assign mul_res[gw*`WORD_W +: `WORD_W] = mul_lane(s_w, d_w); // see [RULE2] [RULE9]
    assign sub_res[gw*`WORD_W +: `WORD_W] = sub_sat(d_w, s_w); // see [RULE7] [RULE10]
  end

  for (genvar gb = 0; gb < `BYTE_LANES; gb++)
  begin : g_byte
    logic [`BYTE_W-1:0] imp_b;
    logic neg, zero, take;
    assign imp_b = imp_val[gb*`BYTE_W +: `BYTE_W];
    assign neg = imp_b[`BYTE_W-1];
    assign zero = ~|imp_b;
    always_comb
    begin
      case (op_sel)
        media_ops_pkg::OP_COND_MOVE_BYTE_NONNEG: take = ~neg; // see [RULE3]
        media_ops_pkg::OP_COND_MOVE_BYTE_NEG: take = neg; // see [RULE4]
        media_ops_pkg::OP_COND_MOVE_BYTE_NONZERO: take = ~zero; // see [RULE5]
        media_ops_pkg::OP_COND_MOVE_BYTE_ZERO: take = zero; // see [RULE6]
        default: take = 1'b0;
      endcase
    end
    // unselected bytes keep the old destination value
    assign cmov_res[gb*`BYTE_W +: `BYTE_W] = take ? mem_operand_i[gb*`BYTE_W +: `BYTE_W]
      : dst_val[gb*`BYTE_W +: `BYTE_W]; // see [RULE4]
  end

  // selectors follow the issue port only while idle, so they hold the multiply's operands through ST_MUL2
  always_comb
  begin
    sel_a_d = sel_a_q;
    sel_b_d = sel_b_q;
    sel_c_d = sel_c_q;
    if (state_q == media_ops_pkg::ST_IDLE)
    begin
      sel_a_d = dest_media_reg_i;
      sel_b_d = src_media_reg_i;
      sel_c_d = implied_sel; // see [RULE11]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sel_a_q <= 3'h0;
      sel_b_q <= 3'h0;
      sel_c_q <= 3'h0;
    end
    else
    begin
      sel_a_q <= sel_a_d;
      sel_b_q <= sel_b_d;
      sel_c_q <= sel_c_d;
    end
  end

  always_comb
  begin
    state_d = state_q;
    res_d = res_q;
    mul_d = mul_q;
    wreg_d = wreg_q;
    valid_d = 1'b0;
    busy_d = busy_q;
    ill_d = 1'b0;
    case (state_q)
      media_ops_pkg::ST_IDLE:
      begin
        busy_d = 1'b0;
        if (issue_i)
        begin
          wreg_d = dest_media_reg_i;
          case (op_sel)
            media_ops_pkg::OP_MUL_HIGH_ROUND_IMPLIED, media_ops_pkg::OP_MUL_HIGH_ROUND:
            begin
              // first clock of the multiply: lane products, retired on the second clock
              mul_d = mul_res; // see [RULE2] [RULE9]
              if (op_sel == media_ops_pkg::OP_MUL_HIGH_ROUND_IMPLIED)
                wreg_d = implied_sel; // see [RULE1] [RULE11]
              busy_d = 1'b1;
              state_d = media_ops_pkg::ST_MUL2; // see [RULE1] [RULE2]
            end
            media_ops_pkg::OP_COND_MOVE_BYTE_NONNEG, media_ops_pkg::OP_COND_MOVE_BYTE_NEG,
            media_ops_pkg::OP_COND_MOVE_BYTE_NONZERO, media_ops_pkg::OP_COND_MOVE_BYTE_ZERO:
            begin
              // register form is not encodable for these: flag it and write nothing
              if (!use_mem)
                ill_d = 1'b1;
              else
              begin
                res_d = cmov_res; // see [RULE3] [RULE4] [RULE5] [RULE6]
                valid_d = 1'b1;
              end
            end
            media_ops_pkg::OP_SUB_SAT_WORD_IMPLIED:
            begin
              res_d = sub_res; // see [RULE7] [RULE9]
              wreg_d = implied_sel; // see [RULE7] [RULE11]
              valid_d = 1'b1;
            end
            default: ill_d = 1'b1;
          endcase
        end
      end
      media_ops_pkg::ST_MUL2:
      begin
        res_d = mul_q;
        valid_d = 1'b1;
        busy_d = 1'b0;
        state_d = media_ops_pkg::ST_IDLE;
      end
      default: state_d = media_ops_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= media_ops_pkg::ST_IDLE;
      res_q <= 64'h0000_0000_0000_0000;
      mul_q <= 64'h0000_0000_0000_0000;
      wreg_q <= 3'h0;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
      ill_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      res_q <= res_d;
      mul_q <= mul_d;
      wreg_q <= wreg_d;
      valid_q <= valid_d;
      busy_q <= busy_d;
      ill_q <= ill_d;
    end
  end

  assign rd_sel_a_o = sel_a_q;
  assign rd_sel_b_o = sel_b_q;
  assign rd_sel_c_o = sel_c_q;
  assign busy_o = busy_q;
  assign result_valid_o = valid_q;
  assign result_reg_o = wreg_q;
  assign result_o = res_q;
  assign illegal_o = ill_q;
endmodule

// ---- design/media_ops_cfg.svh ----
// Operation
// [RULE1] opcode 0F5D: rounded high multiply, bits 30..15 into implied register, two clocks
// [RULE2] opcode 0F59: signed word multiply, add half at bit 15, store 30..15, two clocks
// [RULE3] opcode 0F5C: memory byte moves where implied byte is not negative, one clock
// [RULE4] opcode 0F5B: memory byte moves where implied byte is negative; others kept, one clock
// [RULE5] opcode 0F5A: memory byte moves where implied byte is nonzero, one clock
// [RULE6] opcode 0F58: memory byte moves where implied byte is zero, one clock
// [RULE7] opcode 0F55: named register minus source, saturated words into implied register, one clock
// [RULE8] mod field 11 selects register source; other mod values select memory source
// [RULE9] word operations use four independent 16-bit lanes, msb is sign
// [RULE10] saturated lane results clamp to nearest limit instead of wrapping
// [RULE11] implied register is named register with low selector bit flipped, for read and write
`ifndef MEDIA_OPS_CFG_SVH
`define MEDIA_OPS_CFG_SVH
`define OPC_MUL_HIGH_ROUND_IMPLIED 16'h0F5D
`define OPC_MUL_HIGH_ROUND 16'h0F59
`define OPC_COND_MOVE_BYTE_NONNEG 16'h0F5C
`define OPC_COND_MOVE_BYTE_NEG 16'h0F5B
`define OPC_COND_MOVE_BYTE_NONZERO 16'h0F5A
`define OPC_COND_MOVE_BYTE_ZERO 16'h0F58
`define OPC_SUB_SAT_WORD_IMPLIED 16'h0F55
`define MOD_REG_FORM 2'h3
`define ROUND_HALF 32'h0000_8000
`define PROD_HI 30
`define PROD_LO 15
`define WORD_MAX 16'h7FFF
`define WORD_MIN 16'h8000
`define IMPLIED_XOR 3'h1
`define WORD_W 16
`define BYTE_W 8
`define WORD_LANES 4
`define BYTE_LANES 8
`define MUL_CYCLES 2
`define SIMPLE_CYCLES 1
`endif

// ---- design/media_ops_pkg.sv ----
package media_ops_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_MUL_HIGH_ROUND_IMPLIED,
    OP_MUL_HIGH_ROUND,
    OP_COND_MOVE_BYTE_NONNEG,
    OP_COND_MOVE_BYTE_NEG,
    OP_COND_MOVE_BYTE_NONZERO,
    OP_COND_MOVE_BYTE_ZERO,
    OP_SUB_SAT_WORD_IMPLIED
  } op_e;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MUL2,
    ST_DONE
  } state_e;
endpackage

// ---- tb/ext_packed_media_ops_tail_tb_top.sv ----
`timescale 1ns/1ps
module ext_packed_media_ops_tail_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic issue_i = 1'b0;
  logic [15:0] opcode_i = 16'h0000;
  logic [1:0] modrm_mod_i = 2'h0;
  logic [2:0] dest_media_reg_i = 3'h0;
  logic [2:0] src_media_reg_i = 3'h5;
  logic [63:0] mem_operand_i = 64'h0;
  logic [63:0] rd_a, rd_b, rd_c, result_o;
  logic busy_o, result_valid_o, illegal_o;
  logic [2:0] result_reg_o;
  logic [2:0] sel_a, sel_b, sel_c;
  int errors = 0;
  int n_tests = 0;
  always #5 core_clk_i = ~core_clk_i;
  ext_packed_media_ops_tail ext_packed_media_ops_tail_inst (.core_clk_i, .rst_n_i, .issue_i, .opcode_i,
    .modrm_mod_i, .dest_media_reg_i, .src_media_reg_i, .mem_operand_i, .rd_sel_a_o(sel_a), .rd_sel_b_o(sel_b),
    .rd_sel_c_o(sel_c), .rd_data_a_i(rd_a), .rd_data_b_i(rd_b), .rd_data_c_i(rd_c), .busy_o, .result_valid_o,
    .result_reg_o, .result_o, .illegal_o);
  media_regfile_model media_regfile_model_inst (.dest_sel_i(dest_media_reg_i), .src_sel_i(src_media_reg_i),
    .dest_data_o(rd_a), .src_data_o(rd_b), .impl_data_o(rd_c));
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [63:0] model(input logic [15:0] op, input logic [63:0] d, s, i);
    logic signed [31:0] p;
    logic [16:0] df;
    logic [63:0] r;
    logic c;
    r = d;
    for (int k = 0; k < 4; k++)
    begin
      p = $signed(d[16*k+:16]) * $signed(s[16*k+:16]);
      p = p + 32'h0000_8000;
      df = {d[16*k+15], d[16*k+:16]} - {s[16*k+15], s[16*k+:16]};
      if (op == 16'h0F55)
        r[16*k+:16] = df[16] == df[15] ? df[15:0] : (df[16] ? 16'h8000 : 16'h7FFF);
      if (op == 16'h0F59 || op == 16'h0F5D)
        r[16*k+:16] = p[30:15];
    end
    for (int k = 0; k < 8; k++)
    begin
      case (op)
        16'h0F5C: c = !i[8*k+7];
        16'h0F5B: c = i[8*k+7];
        16'h0F5A: c = |i[8*k+:8];
        16'h0F58: c = ~|i[8*k+:8];
        default: c = 1'b0;
      endcase
      if (c)
        r[8*k+:8] = s[8*k+:8];
    end
    return r;
  endfunction
  task automatic run(input logic [15:0] op, input logic [1:0] md, input logic [2:0] dr,
    input logic [63:0] dv, sv, iv, m);
    logic cm, bad;
    int n;
    cm = op inside {16'h0F58, 16'h0F5A, 16'h0F5B, 16'h0F5C};
    bad = (cm && md == 2'h3) || !(cm || op inside {16'h0F55, 16'h0F59, 16'h0F5D});
    n = 0;
    @(posedge core_clk_i);
    media_regfile_model_inst.mem_q[dr] <= dv;
    media_regfile_model_inst.mem_q[dr ^ 3'h1] <= iv;
    media_regfile_model_inst.mem_q[5] <= sv;
    issue_i <= 1'b1;
    opcode_i <= op;
    modrm_mod_i <= md;
    dest_media_reg_i <= dr;
    mem_operand_i <= m;
    @(posedge core_clk_i);
    issue_i <= 1'b0;
    #1;
    cmp("selectors", {55'h0, dr, 3'h5, dr ^ 3'h1}, {55'h0, sel_a, sel_b, sel_c});
    while (result_valid_o !== 1'b1 && illegal_o !== 1'b1 && n < 4)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    cmp("illegal", {63'h0, bad}, {63'h0, illegal_o});
    if (!bad)
    begin
      cmp("cycles", (op == 16'h0F59 || op == 16'h0F5D) ? 64'h1 : 64'h0, 64'(n));
      cmp("reg", {61'h0, (op == 16'h0F59 || cm) ? dr : dr ^ 3'h1}, {61'h0, result_reg_o});
      cmp("result", model(op, dv, md == 2'h3 ? sv : m, iv), result_o);
    end
  endtask
  task automatic test_mul();
    run(16'h0F59, 2'h3, 3'h2, 64'h8000_7FFF_FFFF_0003, 64'h8000_7FFF_0001_4000, 64'h0, 64'h0);
    run(16'h0F59, 2'h0, 3'h3, 64'h1234_8001_0100_FFFE, 64'h0, 64'h0, 64'h4321_7FFF_0080_FFFF);
    $display("mul done");
  endtask
  task automatic test_muli();
    run(16'h0F5D, 2'h1, 3'h2, 64'h8000_C000_0005_7FFF, 64'h0, 64'h5A5A, 64'h8000_4000_3000_8001);
    run(16'h0F5D, 2'h3, 3'h3, 64'hFFFF_0002_8000_1111, 64'h0001_0003_0001_2222, 64'h0, 64'h0);
    $display("muli done");
  endtask
  task automatic test_cmov();
    logic [15:0] ops [4] = '{16'h0F5C, 16'h0F5B, 16'h0F5A, 16'h0F58};
    foreach (ops[j])
      run(ops[j], 2'h0, 3'h2, 64'h1111_2222_3333_4444, 64'h0, 64'h0080_7FFF_0100_81FE,
        64'hAAAA_BBBB_CCCC_DDDD);
    run(16'h0F5B, 2'h3, 3'h3, 64'h0, 64'h0, 64'h0, 64'h0);
    run(16'h0F56, 2'h3, 3'h1, 64'h0, 64'h0, 64'h0, 64'h0);
    $display("cmov done");
  endtask
  task automatic test_sub();
    run(16'h0F55, 2'h3, 3'h3, 64'h7FFF_8000_0005_8000, 64'hFFFF_0001_0007_8000, 64'h0, 64'h0);
    run(16'h0F55, 2'h2, 3'h2, 64'h8001_7FFE_0000_1234, 64'h0, 64'h0, 64'h0002_FFFE_8000_1234);
    $display("sub done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    test_mul();
    test_muli();
    test_cmov();
    test_sub();
    complete_run();
  end
  initial
  begin
    repeat (1000) @(posedge core_clk_i);
    errors++;
    complete_run();
  end
endmodule

// ---- tb/media_ops_assertions.sv ----
`timescale 1ns/1ps
module media_ops_assertions (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // issue
  input wire logic issue_i,
  input wire logic [15:0] opcode_i,
  input wire logic [1:0] modrm_mod_i,
  input wire logic [2:0] dest_media_reg_i,
  // result
  input wire logic busy_o,
  input wire logic result_valid_o,
  input wire logic [2:0] result_reg_o,
  input wire logic illegal_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic tk, cm, rf;
  logic [2:0] dr;
  assign tk = issue_i && !busy_o;
  // 0F59 sits inside the conditional-move code range but is a multiply
  assign cm = opcode_i inside {16'h0F58, 16'h0F5A, 16'h0F5B, 16'h0F5C};
  assign rf = modrm_mod_i == 2'h3;
  assign dr = dest_media_reg_i;
  AST_MUL_TWO: assert property (tk && opcode_i == 16'h0F59 |=>
    busy_o && !result_valid_o ##1 result_valid_o && result_reg_o == $past(dr, 2)) else $error("mul timing");
  AST_MULI_TWO: assert property (tk && opcode_i == 16'h0F5D |=>
    busy_o ##1 result_valid_o && result_reg_o == ($past(dr, 2) ^ 3'h1)) else $error("muli timing");
  AST_SUB_ONE: assert property (tk && opcode_i == 16'h0F55 |=>
    result_valid_o && result_reg_o == ($past(dr) ^ 3'h1)) else $error("sub timing");
  AST_CMOV_ONE: assert property (tk && cm && !rf |=>
    result_valid_o && !busy_o && result_reg_o == $past(dr)) else $error("cmov timing");
  AST_CMOV_MEM_ONLY: assert property (tk && cm && rf |=> illegal_o && !result_valid_o)
    else $error("cmov reg form taken");
  AST_REG_FORM_OK: assert property (tk && rf && opcode_i inside {16'h0F55, 16'h0F59, 16'h0F5D}
    |-> ##1 !illegal_o) else $error("reg form refused");
  AST_BUSY_ONE: assert property (busy_o |=> !busy_o && result_valid_o)
    else $error("busy length");
  AST_VALID_CAUSE: assert property ($rose(result_valid_o) |-> $past(tk) || $past(busy_o))
    else $error("result without issue");
  cover property (tk && opcode_i == 16'h0F59);
  cover property (tk && cm && !rf);
  cover property (illegal_o);
  cover property (tk && opcode_i == 16'h0F55);
endmodule
bind ext_packed_media_ops_tail media_ops_assertions media_ops_assertions_inst (.core_clk_i, .rst_n_i,
  .issue_i, .opcode_i, .modrm_mod_i, .dest_media_reg_i, .busy_o, .result_valid_o, .result_reg_o, .illegal_o);

// ---- tb/media_regfile_model.sv ----
`timescale 1ns/1ps
module media_regfile_model (
  // selectors from the issue port
  input wire logic [2:0] dest_sel_i,
  input wire logic [2:0] src_sel_i,
  // read data
  output logic [63:0] dest_data_o,
  output logic [63:0] src_data_o,
  output logic [63:0] impl_data_o
);
  logic [63:0] mem_q [8];
  // indexed by the live selectors: the registered copies lag the issue cycle by one
  assign dest_data_o = mem_q[dest_sel_i];
  assign src_data_o = mem_q[src_sel_i];
  assign impl_data_o = mem_q[dest_sel_i ^ 3'h1];
endmodule
